// ### dv/mbf_bus_asserts.sv
// Concurrent checks on the pins joining the host end and the device end.
`timescale 1ns/10ps
module mbf_bus_asserts #(
  parameter int STROBE_CYC = 3,
  parameter int RESET_HOLD_CYC = 25
) (
  input logic clock,
  input logic rst_b,
  input logic [7:0] upper_dev_o,
  input logic upper_dev_oe,
  input logic upper_host_oe,
  input logic addr_valid_strobe,
  input logic control_input_zero,
  input logic dev_reset_b
);
  // ====
  // Helper counters.
  logic [7:0] rcnt_q, rcnt_d, ocnt_q, ocnt_d;
  always_comb begin
    rcnt_d = (rcnt_q == 8'hFF) ? rcnt_q : rcnt_q + 8'h01;
    ocnt_d = upper_dev_oe ? ocnt_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rcnt_q <= 8'h00;
      ocnt_q <= 8'h00;
    end else begin
      rcnt_q <= rcnt_d;
      ocnt_q <= ocnt_d;
    end
  end
  // ====
  // Properties.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_one_drv; !(upper_dev_oe && upper_host_oe); endproperty
  a_one_drv: assert property (p_one_drv) else $error("both ends drive upper port");
  property p_oe_rd; upper_dev_oe |-> control_input_zero; endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("upper driven in write cycle");
  property p_oe_noas; upper_dev_oe |-> !addr_valid_strobe; endproperty
  a_oe_noas: assert property (p_oe_noas) else $error("upper driven in address phase");
  property p_oe_rst; !dev_reset_b |-> !upper_dev_oe; endproperty
  a_oe_rst: assert property (p_oe_rst) else $error("upper driven in reset");
  property p_rise_quiet; $rose(dev_reset_b) |-> !upper_dev_oe [*2]; endproperty
  a_rise_quiet: assert property (p_rise_quiet) else $error("drive too soon after reset");
  property p_as_pulse; addr_valid_strobe |=> !addr_valid_strobe; endproperty
  a_as_pulse: assert property (p_as_pulse) else $error("address strobe longer than one cycle");
  property p_as_live; addr_valid_strobe |-> dev_reset_b; endproperty
  a_as_live: assert property (p_as_live) else $error("bus cycle while device in reset");
  property p_hold; dev_reset_b |-> rcnt_q >= RESET_HOLD_CYC; endproperty
  a_hold: assert property (p_hold) else $error("device reset released early");
  property p_oe_len; upper_dev_oe |-> ocnt_q < STROBE_CYC + 2; endproperty
  a_oe_len: assert property (p_oe_len) else $error("upper driven too long");
  property p_oe_data; upper_dev_oe && $past(upper_dev_oe) |-> $stable(upper_dev_o); endproperty
  a_oe_data: assert property (p_oe_data) else $error("read data changed while driven");
  c_dev_rd: cover property ($rose(upper_dev_oe));
  c_host_wr: cover property ($rose(upper_host_oe));
  c_strobe: cover property (addr_valid_strobe);
endmodule // mbf_bus_asserts

// ### dv/tb.sv
// Self-checking bench joining both ends through the bus interface.
`timescale 1ns/10ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module tb;
  import mbf_pkg::*;
  localparam int HOLD = 2;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  mbf_c0_mode_t c0 = MBF_C0_WR_STROBE;
  mbf_c1_mode_t c1 = MBF_C1_RD;
  mbf_bus_mode_t bm = MBF_BUS_LOW_MUX;
  logic has_f = 1'b0, gen_out = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_code = 1'b0, func_sel = 1'b0;
  logic [19:0] req_addr = MBF_ADDR_ZERO;
  logic [7:0] req_wdata = 8'h00, rd_data = 8'h00, rdata;
  logic req_ready, done, generic_in, rd_cycle, wr_cycle, code_fetch, rd_pulse, wr_pulse, in_reset;
  logic [19:0] decode_addr;
  logic [2:0] ctl;
  logic s_rd, s_wr, s_cf, s_rc, s_wc;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] rnd = 32'h8D62B54F;
  mbf_bus_if bus_if ();
  always #20 clock = ~clock;
  mbf_host_end #(.STROBE_CYC(3), .RESET_HOLD_CYC(HOLD)) u_mbf_host_end (.clock(clock), .rst_b(rst_b),
    .bus(bus_if), .cfg_c0_mode(c0), .cfg_c1_mode(c1), .cfg_bus_mode(bm), .cfg_has_fetch(has_f),
    .gen_out(gen_out), .req_valid(req_valid), .req_write(req_write), .req_code(req_code), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .done(done), .rdata(rdata));
  mbf_device_end u_mbf_device_end (.clock(clock), .rst_b(rst_b), .bus(bus_if), .cfg_c0_mode(c0),
    .cfg_c1_mode(c1), .cfg_bus_mode(bm), .cfg_has_fetch(has_f), .func_sel(func_sel), .rd_data(rd_data),
    .decode_addr(decode_addr), .ctl_to_logic(ctl), .generic_in(generic_in), .rd_cycle(rd_cycle),
    .wr_cycle(wr_cycle), .code_fetch(code_fetch), .rd_pulse(rd_pulse), .wr_pulse(wr_pulse), .in_reset(in_reset));
  mbf_bus_asserts #(.STROBE_CYC(3), .RESET_HOLD_CYC(HOLD)) u_mbf_bus_asserts (.clock(clock), .rst_b(rst_b),
    .upper_dev_o(bus_if.upper_dev_o), .upper_dev_oe(bus_if.upper_dev_oe), .upper_host_oe(bus_if.upper_host_oe),
    .addr_valid_strobe(bus_if.addr_valid_strobe), .control_input_zero(bus_if.control_input_zero),
    .dev_reset_b(bus_if.dev_reset_b));
  // ====
  // Expectations and helpers.
  always @(negedge clock) begin
    if (rd_pulse === 1'b1) s_rd = 1'b1;
    if (wr_pulse === 1'b1) s_wr = 1'b1;
    if (code_fetch === 1'b1) s_cf = 1'b1;
    if (rd_cycle === 1'b1) s_rc = 1'b1;
    if (wr_cycle === 1'b1) s_wc = 1'b1;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Burst hosts put A19..A4 on the pins, so the low nibble is not compared.
  function automatic logic [19:0] amask(input mbf_bus_mode_t m);
    return (m == MBF_BUS_BURST) ? 20'hFFFF0 : 20'h0FFFF;
  endfunction
  // Address-only hosts keep the upper byte driven, so a read there sees its own address.
  function automatic logic [7:0] exp_rd(input mbf_bus_mode_t m, input logic sel, input logic [7:0] d,
                                        input logic [19:0] a);
    if (m == MBF_BUS_PAGE || m == MBF_BUS_BURST) return sel ? d : MBF_PIN_IDLE;
    return a[MBF_UP_LSB_STD +: 8];
  endfunction
  // Idle strobes sit high, except the E clock, which is high only in the data phase.
  function automatic logic [2:0] idle_ctl(input mbf_c1_mode_t m, input logic f, input logic g);
    return {f ? 1'b1 : g, m != MBF_C1_ECLK, 1'b1};
  endfunction
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic fail_wait();
    n_errors++;
    $display("[FAIL] wait bound expected 0 seen 1");
    end_of_test();
  endtask
  task automatic do_reset();
    int i;
    @(posedge clock);
    #1 rst_b = 1'b0;
    repeat (5) @(posedge clock);
    `CHK("in_reset", 1'b1, in_reset)
    #1 rst_b = 1'b1;
    for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(negedge clock);
    if (i == 40) fail_wait();
    `CHK("in_reset", 1'b1, in_reset)
    repeat (2) @(negedge clock);
    `CHK("in_reset", 1'b0, in_reset)
    @(negedge clock);
    `CHK("decode_addr", MBF_ADDR_ZERO, decode_addr)
    `CHK("ctl", idle_ctl(c1, has_f, gen_out), ctl)
    if (!has_f) `CHK("generic_in", gen_out, generic_in)
  endtask
  task automatic xfer(input logic w, input logic cd, input logic [19:0] a, input logic [7:0] d, input logic sel);
    int i;
    @(posedge clock);
    #1 req_valid = 1'b1;
    req_write = w;
    req_code = cd;
    req_addr = a;
    req_wdata = d;
    rd_data = d;
    func_sel = sel;
    s_rd = 1'b0;
    s_wr = 1'b0;
    s_cf = 1'b0;
    s_rc = 1'b0;
    s_wc = 1'b0;
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge clock);
    if (i == 20) fail_wait();
    @(posedge clock);
    #1 req_valid = 1'b0;
    for (i = 0; i < 20 && done !== 1'b1; i++) @(negedge clock);
    if (i == 20) fail_wait();
    `CHK("decode_addr", a & amask(bm), decode_addr & amask(bm))
    if (!w) `CHK("rdata", exp_rd(bm, sel, d, a), rdata)
    repeat (2) @(negedge clock);
    `CHK("decode_addr held", a & amask(bm), decode_addr & amask(bm))
    `CHK("wr_pulse", w, s_wr)
    `CHK("wr_cycle", w, s_wc)
    if (!cd) `CHK("rd_pulse", !w, s_rd)
    if (!cd) `CHK("rd_cycle", !w, s_rc)
    if (cd && has_f) `CHK("code_fetch", 1'b1, s_cf)
  endtask
  // ====
  // Main sequence: every mode combination, corner cycles then random ones.
  initial begin
    for (int k = 0; k < 32; k++) begin
      @(posedge clock);
      #1 c0 = mbf_c0_mode_t'(k[0]);
      c1 = mbf_c1_mode_t'(k[2:1]);
      bm = mbf_bus_mode_t'(k[4:3]);
      rnd = lfsr(rnd);
      has_f = rnd[0];
      gen_out = rnd[1];
      do_reset();
      xfer(1'b1, 1'b0, 20'hFFFFF, 8'h00, 1'b1);
      xfer(1'b0, 1'b0, 20'h00000, 8'hFF, 1'b1);
      xfer(1'b0, 1'b0, 20'hA5A5A, 8'h3C, 1'b0);
      xfer(1'b0, 1'b1, 20'h5A5A5, 8'hC3, 1'b1);
      repeat (3) begin
        rnd = lfsr(rnd);
        xfer(rnd[0], rnd[1] & ~rnd[0], rnd[21:2], rnd[29:22], rnd[30]);
      end
      $display("test %0d done mismatches %0d", k, n_errors);
    end
    end_of_test();
  end
endmodule // tb

// ### hdl/mbf_device_end.sv
// Device end: host-facing front end that latches addresses and decodes strobes.
//
// Notes on behaviour
// [R1] Address strobe captures upper port into latch.
// [R2] Drive upper port only on selected read.
// [R3] Latched upper addresses feed the decode logic.
// [R4] Separate write strobe: low on input zero.
// [R5] Direction line: high read, low write.
// [R6] Input one decoded per configured host signal.
// [R7] Wide-address hosts wire fetch strobe to one.
// [R8] Input two is fetch strobe or generic.
// [R9] All three control inputs reach user logic.
// [R10] Reset clears ports, macrocell and configuration state.
// [R11] Reset pin held low during power-up.
// [R12] Plain or low-mux hosts: upper carries address.
// [R13] Page mode: upper carries address and data.
// [R14] Burst mode: upper carries A12-A19 with D8-D15.
// [R15] Low-mux hosts connect lines zero-seven lower.
// [R16] Latched address held until next strobe.
// [R17] Reset release synchronised to the clock.
`timescale 1ns/10ps
module mbf_device_end
  import mbf_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  mbf_bus_if.dev bus,
  input wire mbf_c0_mode_t cfg_c0_mode,
  input wire mbf_c1_mode_t cfg_c1_mode,
  input wire mbf_bus_mode_t cfg_bus_mode,
  input wire logic cfg_has_fetch,
  input wire logic func_sel,
  input wire logic [7:0] rd_data,
  output logic [19:0] decode_addr,
  output logic [2:0] ctl_to_logic,
  output logic generic_in,
  output logic rd_cycle,
  output logic wr_cycle,
  output logic code_fetch,
  output logic rd_pulse,
  output logic wr_pulse,
  output logic in_reset
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [1:0] sync;
  } mbf_dsync_t;

  typedef struct packed {
    logic [7:0] latch_hi;
    logic [7:0] latch_lo;
    logic latched;
    logic [7:0] dout;
    logic [2:0] ctl;
    logic rd_prev;
    logic wr_prev;
    logic rd_pulse;
    logic wr_pulse;
  } mbf_dreg_t;

  localparam mbf_dsync_t DSYNC_RESET = '{sync: 2'h0};
  // Control strobes other than the E clock idle high, so the reset image of the control copy is all ones.
  localparam mbf_dreg_t DREG_RESET = '{
    latch_hi: MBF_BYTE_ZERO,
    latch_lo: MBF_BYTE_ZERO,
    latched: 1'b0,
    dout: MBF_BYTE_ZERO,
    ctl: 3'h7,
    rd_prev: 1'b0,
    wr_prev: 1'b0,
    rd_pulse: 1'b0,
    wr_pulse: 1'b0
  };

  mbf_dsync_t s_q;
  mbf_dsync_t s_d;
  mbf_dreg_t q;
  mbf_dreg_t d;
  logic arst_b;
  logic run_b;
  logic rd_act;
  logic wr_act;
  logic strobe_on;
  logic data_on_upper;

  // ==========================================================================
  // Elaboration checks
  // The pin slices are fixed at one byte each; a package change that moved a
  // slice past the top of the address would silently lose decode bits.
  if (MBF_DW != 8) $error("data width must be one byte");
  if (MBF_AW != 20) $error("address width must be twenty bits");
  if (MBF_UP_LSB_BURST + MBF_DW > MBF_AW) $error("burst upper slice exceeds address");
  if (MBF_UP_LSB_STD + MBF_DW > MBF_AW) $error("upper slice exceeds address");
  if (MBF_LO_LSB_BURST + MBF_DW > MBF_UP_LSB_BURST) $error("burst lower slice overlaps upper");
  if (MBF_LO_LSB_STD + MBF_DW > MBF_UP_LSB_STD) $error("lower slice overlaps upper");
  if (MBF_UP_LSB_BURST - MBF_LO_LSB_BURST != MBF_DW) $error("burst slices must abut");
  if (MBF_UP_LSB_STD - MBF_LO_LSB_STD != MBF_DW) $error("slices must abut");

  // ==========================================================================
  // Reset
  // Either the system reset or the device pin asserts at once; release is
  // taken through two flip-flops so no macrocell leaves reset mid-cycle.
  assign arst_b = rst_b & bus.dev_reset_b; // [R10]

  always_comb begin
    s_d.sync = {s_q.sync[0], 1'b1}; // [R17]
  end

  always_ff @(posedge clock or negedge arst_b) begin
    if (!arst_b) begin
      s_q <= DSYNC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign run_b = s_q.sync[1]; // [R17]

  // ==========================================================================
  // Strobe decode
  // Inputs are taken as synchronous to the clock, so they are decoded directly.
  always_comb begin
    case (cfg_c1_mode)
      MBF_C1_ECLK: begin
        strobe_on = bus.control_input_one; // [R6]
        rd_act = bus.control_input_one && bus.control_input_zero; // [R5] [R6]
      end
      MBF_C1_DS: begin
        strobe_on = !bus.control_input_one; // [R6]
        rd_act = !bus.control_input_one && bus.control_input_zero; // [R5] [R6]
      end
      MBF_C1_FETCH_RD: begin
        strobe_on = !bus.control_input_one; // [R7]
        rd_act = !bus.control_input_one; // [R6]
      end
      default: begin
        strobe_on = !bus.control_input_one; // [R6]
        rd_act = !bus.control_input_one; // [R6]
      end
    endcase
    if (cfg_c0_mode == MBF_C0_WR_STROBE) begin
      wr_act = !bus.control_input_zero; // [R4]
    end else if (cfg_c1_mode == MBF_C1_ECLK || cfg_c1_mode == MBF_C1_DS) begin
      wr_act = !bus.control_input_zero && strobe_on; // [R5]
    end else begin
      // A bare direction line has no strobe, so the address phase is excluded.
      wr_act = !bus.control_input_zero && !bus.addr_valid_strobe; // [R5]
    end
  end

  // ==========================================================================
  // Registered front end
  always_comb begin
    d = q;
    if (bus.addr_valid_strobe) begin
      d.latch_hi = bus.upper_addr_data_port; // [R1]
      d.latch_lo = bus.lower_addr_data_port;
      d.latched = 1'b1;
    end
    // Outside the strobe the latch keeps its value so decode stays valid. [R16]
    d.dout = rd_data;
    d.ctl = {bus.control_input_two, bus.control_input_one, bus.control_input_zero}; // [R9]
    d.rd_prev = rd_act;
    d.wr_prev = wr_act;
    d.rd_pulse = rd_act && !q.rd_prev;
    d.wr_pulse = wr_act && !q.wr_prev;
  end

  always_ff @(posedge clock or negedge run_b) begin
    if (!run_b) begin
      q <= DREG_RESET; // [R10]
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Port drive and decode outputs
  // Only page and burst hosts carry data on the upper port; in the other modes
  // the port is address only and is never turned round.
  assign data_on_upper = (cfg_bus_mode == MBF_BUS_PAGE) || (cfg_bus_mode == MBF_BUS_BURST); // [R12] [R13] [R14]

  always_comb begin
    bus.upper_dev_oe = run_b && rd_act && func_sel && data_on_upper; // [R2]
    bus.upper_dev_o = q.dout; // [R2]
  end

  always_comb begin
    decode_addr = MBF_ADDR_ZERO;
    if (cfg_bus_mode == MBF_BUS_BURST) begin
      decode_addr[MBF_UP_LSB_BURST +: 8] = q.latch_hi; // [R3] [R14]
      decode_addr[MBF_LO_LSB_BURST +: 8] = q.latch_lo;
    end else begin
      decode_addr[MBF_UP_LSB_STD +: 8] = q.latch_hi; // [R3] [R12] [R13]
      decode_addr[MBF_LO_LSB_STD +: 8] = q.latch_lo;
    end
  end

  assign ctl_to_logic = q.ctl; // [R9]
  assign code_fetch = run_b && cfg_has_fetch && !q.ctl[2]; // [R8]
  assign generic_in = !cfg_has_fetch && q.ctl[2]; // [R8]
  assign rd_cycle = run_b && q.rd_prev;
  assign wr_cycle = run_b && q.wr_prev;
  assign rd_pulse = q.rd_pulse;
  assign wr_pulse = q.wr_pulse;
  assign in_reset = !run_b;

endmodule // mbf_device_end

// ### hdl/mbf_host_end.sv
// Host end: runs one bus cycle per request and drives the device reset pin.
`timescale 1ns/10ps
module mbf_host_end
  import mbf_pkg::*;
#(
  parameter int STROBE_CYC = MBF_STROBE_CYC,
  parameter int RESET_HOLD_CYC = MBF_RESET_HOLD_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  mbf_bus_if.host bus,
  input wire mbf_c0_mode_t cfg_c0_mode,
  input wire mbf_c1_mode_t cfg_c1_mode,
  input wire mbf_bus_mode_t cfg_bus_mode,
  input wire logic cfg_has_fetch,
  input wire logic gen_out,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_code,
  input wire logic [19:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic done,
  output logic [7:0] rdata
);

  if (STROBE_CYC < 1 || STROBE_CYC > 255) $error("STROBE_CYC out of range");
  if (RESET_HOLD_CYC < 1 || RESET_HOLD_CYC > 65535) $error("RESET_HOLD_CYC out of range");

  typedef enum logic [2:0] {
    MBF_H_IDLE = 3'h0,
    MBF_H_ADDR = 3'h1,
    MBF_H_HOLD = 3'h3,
    MBF_H_STROBE = 3'h2,
    MBF_H_RECOV = 3'h6
  } mbf_hstate_t;

  typedef struct packed {
    mbf_hstate_t st;
    logic [7:0] cnt;
    logic [15:0] rst_cnt;
    logic rst_done;
    logic [19:0] addr;
    logic [7:0] wdata;
    logic write;
    logic code;
    logic [7:0] rdata;
    logic done;
  } mbf_hreg_t;

  localparam mbf_hreg_t HREG_RESET = '{MBF_H_IDLE, 8'h00, 16'h0000, 1'b0, MBF_ADDR_ZERO,
                                       MBF_BYTE_ZERO, 1'b0, 1'b0, MBF_BYTE_ZERO, 1'b0};

  mbf_hreg_t q;
  mbf_hreg_t d;
  logic data_on_upper;
  logic in_cycle;
  logic strobe;

  always_comb begin
    d = q;
    d.done = 1'b0;
    // Device reset pin is held low from power-up for a fixed time. [R11]
    if (!q.rst_done) begin
      d.rst_cnt = q.rst_cnt + 16'h0001;
      d.rst_done = (q.rst_cnt == 16'(RESET_HOLD_CYC - 1));
    end
    case (q.st)
      MBF_H_IDLE: begin
        if (req_valid && q.rst_done) begin
          d.st = MBF_H_ADDR;
          d.addr = req_addr;
          d.wdata = req_wdata;
          d.write = req_write;
          d.code = req_code;
        end
      end
      MBF_H_ADDR: d.st = MBF_H_HOLD;
      MBF_H_HOLD: begin
        d.st = MBF_H_STROBE;
        d.cnt = 8'(STROBE_CYC - 1);
      end
      MBF_H_STROBE: begin
        if (q.cnt == 8'h00) begin
          d.st = MBF_H_RECOV;
          d.rdata = bus.upper_addr_data_port;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      MBF_H_RECOV: begin
        d.st = MBF_H_IDLE;
        d.done = 1'b1;
      end
      default: d.st = MBF_H_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= HREG_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Pin decode
  assign data_on_upper = (cfg_bus_mode == MBF_BUS_PAGE) || (cfg_bus_mode == MBF_BUS_BURST); // [R13] [R14]
  assign in_cycle = (q.st != MBF_H_IDLE);
  assign strobe = (q.st == MBF_H_STROBE);

  always_comb begin
    bus.addr_valid_strobe = (q.st == MBF_H_ADDR);
    bus.dev_reset_b = q.rst_done;
    bus.upper_host_oe = in_cycle && !(strobe && data_on_upper && !q.write);
    if (strobe && data_on_upper) begin
      bus.upper_host_o = q.wdata; // [R13] [R14]
    end else if (cfg_bus_mode == MBF_BUS_BURST) begin
      bus.upper_host_o = q.addr[MBF_UP_LSB_BURST +: 8]; // [R14]
    end else begin
      bus.upper_host_o = q.addr[MBF_UP_LSB_STD +: 8]; // [R12] [R13]
    end
    if (strobe && cfg_bus_mode == MBF_BUS_LOW_MUX) begin
      bus.lower_addr_data_port = q.wdata; // [R15]
    end else if (cfg_bus_mode == MBF_BUS_BURST) begin
      bus.lower_addr_data_port = q.addr[MBF_LO_LSB_BURST +: 8];
    end else begin
      bus.lower_addr_data_port = q.addr[MBF_LO_LSB_STD +: 8]; // [R15]
    end
    if (cfg_c0_mode == MBF_C0_WR_STROBE) begin
      bus.control_input_zero = !(strobe && q.write); // [R4]
    end else begin
      bus.control_input_zero = !(in_cycle && q.write); // [R5]
    end
    case (cfg_c1_mode)
      MBF_C1_ECLK: bus.control_input_one = strobe; // [R6]
      MBF_C1_DS: bus.control_input_one = !strobe; // [R6]
      MBF_C1_FETCH_RD: bus.control_input_one = !(strobe && !q.write); // [R7]
      default: bus.control_input_one = !(strobe && !q.write); // [R6]
    endcase
    bus.control_input_two = cfg_has_fetch ? !(strobe && q.code && !q.write) : gen_out;
  end

  assign req_ready = (q.st == MBF_H_IDLE) && q.rst_done;
  assign done = q.done;
  assign rdata = q.rdata;

endmodule // mbf_host_end

// ### inc/mbf_bus_if.sv
// Pin-level carrier joining the host end and the device end.
`timescale 1ns/10ps
interface mbf_bus_if;
  import mbf_pkg::*;

  logic [7:0] upper_host_o;
  logic upper_host_oe;
  logic [7:0] upper_dev_o;
  logic upper_dev_oe;
  logic [7:0] upper_addr_data_port;
  logic [7:0] lower_addr_data_port;
  logic addr_valid_strobe;
  logic control_input_zero;
  logic control_input_one;
  logic control_input_two;
  logic dev_reset_b;

  // ==========================================================================
  // Wire resolution; an undriven port floats high through its pull-up.
  assign upper_addr_data_port = upper_dev_oe ? upper_dev_o : (upper_host_oe ? upper_host_o : MBF_PIN_IDLE);

  modport dev (
    input upper_addr_data_port,
    input lower_addr_data_port,
    input addr_valid_strobe,
    input control_input_zero,
    input control_input_one,
    input control_input_two,
    input dev_reset_b,
    output upper_dev_o,
    output upper_dev_oe
  );

  modport host (
    input upper_addr_data_port,
    output upper_host_o,
    output upper_host_oe,
    output lower_addr_data_port,
    output addr_valid_strobe,
    output control_input_zero,
    output control_input_one,
    output control_input_two,
    output dev_reset_b
  );
endinterface

// ### inc/mbf_pkg.sv
// Shared constants and types for both ends of the microcontroller bus front end.
package mbf_pkg;

  // ==========================================================================
  // Widths and address layout
  localparam int MBF_DW = 8;
  localparam int MBF_AW = 20;
  localparam int MBF_UP_LSB_STD = 8;
  localparam int MBF_UP_LSB_BURST = 12;
  localparam int MBF_LO_LSB_STD = 0;
  localparam int MBF_LO_LSB_BURST = 4;
  localparam logic [7:0] MBF_PIN_IDLE = 8'hFF;
  localparam logic [7:0] MBF_BYTE_ZERO = 8'h00;
  localparam logic [19:0] MBF_ADDR_ZERO = 20'h00000;

  // ==========================================================================
  // Configuration choices
  typedef enum logic {
    MBF_C0_WR_STROBE = 1'b0,
    MBF_C0_RW_LINE = 1'b1
  } mbf_c0_mode_t;

  typedef enum logic [1:0] {
    MBF_C1_RD = 2'h0,
    MBF_C1_ECLK = 2'h1,
    MBF_C1_DS = 2'h2,
    MBF_C1_FETCH_RD = 2'h3
  } mbf_c1_mode_t;

  typedef enum logic [1:0] {
    MBF_BUS_LOW_MUX = 2'h0,
    MBF_BUS_NONMUX = 2'h1,
    MBF_BUS_PAGE = 2'h2,
    MBF_BUS_BURST = 2'h3
  } mbf_bus_mode_t;

  // ==========================================================================
  // Timing
  localparam int MBF_CLK_MHZ = 25;
  localparam int MBF_CLK_PERIOD_NS = 1000 / MBF_CLK_MHZ;
  localparam int MBF_STROBE_MIN_NS = 120;
  localparam int MBF_STROBE_CYC = (MBF_STROBE_MIN_NS + MBF_CLK_PERIOD_NS - 1) / MBF_CLK_PERIOD_NS;
  localparam int MBF_RESET_HOLD_NS = 1000;
  localparam int MBF_RESET_HOLD_CYC = (MBF_RESET_HOLD_NS + MBF_CLK_PERIOD_NS - 1) / MBF_CLK_PERIOD_NS;

endpackage
